/* File: bench/ptp_clock_counter_irq_sva.sv */
`timescale 1ns/10ps
// ===========================================================================
// Port checker for the time counter.
module ptp_clock_counter_irq_sva
  import ptp_clock_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        resetn,
  // Register port.
  input wire logic [11:0] regAddr,
  input wire logic [31:0] regWriteData,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [31:0] regReadData,
  // Events and outputs.
  input wire logic [7:0]  gpioPins,
  input wire logic [7:0]  manualCapture,
  input wire logic [1:0]  targetClearEnable,
  input wire logic        txStamped,
  input wire logic        rxStamped,
  input wire logic [31:0] liveSeconds,
  input wire logic [29:0] liveNanoseconds,
  input wire logic        timeEventSummary,
  input wire logic        systemIrq
);
  logic [2:0]  quiet;
  logic [31:0] enShadow;
  logic        sysEn;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Counts cycles since a load command and mirrors the enable word.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      quiet    <= 3'h0;
      enShadow <= 32'h0;
      sysEn    <= 1'b0;
    end else begin
      if (regWrite && regAddr == ADDR_COMMAND && regWriteData[BIT_CMD_LOAD]) quiet <= 3'h0;
      else if (quiet != 3'h4) quiet <= quiet + 3'h1;
      if (regWrite && regAddr == ADDR_IRQ_ENABLE) enShadow <= regWriteData & STATUS_MASK;
      if (regWrite && regAddr == ADDR_SYS_IRQ) sysEn <= regWriteData[BIT_SYS_EVENT];
    end
  end
  // True when one step of the nanoseconds count is 9, 10 or 11.
  function automatic logic stepOk(input logic [29:0] now, input logic [29:0] was);
    logic [31:0] d;
    d = {2'h0, now} - {2'h0, was};
    if (now < was) d = d + NS_PER_SECOND;
    return (d >= STEP_SLOW) && (d <= STEP_FAST);
  endfunction : stepOk
  sequence s_txPulse; txStamped && enShadow[BIT_TX_STAMP] && !regWrite; endsequence
  property p_step; quiet == 3'h4 |-> stepOk(liveNanoseconds, $past(liveNanoseconds)); endproperty
  property p_range; {2'h0, liveNanoseconds} < NS_PER_SECOND; endproperty
  property p_carry;
    quiet == 3'h4 && liveSeconds != $past(liveSeconds)
      |-> liveSeconds == $past(liveSeconds) + 32'h1 && liveNanoseconds < 30'hB;
  endproperty
  property p_idle; !$past(regRead) |-> regReadData == RESET_WORD; endproperty
  property p_hole; regRead && regAddr == 12'h104 |=> regReadData == RESET_WORD; endproperty
  property p_enable; regRead && regAddr == ADDR_IRQ_ENABLE |=> regReadData == enShadow; endproperty
  property p_tx; s_txPulse |=> timeEventSummary; endproperty
  property p_sys; systemIrq == (timeEventSummary && sysEn); endproperty
  property p_masked; enShadow == RESET_WORD |-> !timeEventSummary; endproperty
  a_step: assert property (p_step) else $error("bad nanoseconds step");
  a_range: assert property (p_range) else $error("nanoseconds out of range");
  a_carry: assert property (p_carry) else $error("bad seconds carry");
  a_idle: assert property (p_idle) else $error("read data without read");
  a_hole: assert property (p_hole) else $error("unmapped read not zero");
  a_enable: assert property (p_enable) else $error("enable readback wrong");
  a_tx: assert property (p_tx) else $error("enabled flag not in summary");
  a_sys: assert property (p_sys) else $error("system interrupt gating wrong");
  a_masked: assert property (p_masked) else $error("summary with no enables");
endmodule : ptp_clock_counter_irq_sva
bind ptp_clock_counter_irq ptp_clock_counter_irq_sva chk (.clk_sys(clk_sys), .resetn(resetn),
  .regAddr(regAddr), .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
  .regReadData(regReadData), .gpioPins(gpioPins), .manualCapture(manualCapture),
  .targetClearEnable(targetClearEnable), .txStamped(txStamped), .rxStamped(rxStamped),
  .liveSeconds(liveSeconds), .liveNanoseconds(liveNanoseconds),
  .timeEventSummary(timeEventSummary), .systemIrq(systemIrq));

/* File: bench/tb.sv */
`timescale 1ns/10ps
// ===========================================================================
// Self-checking bench for the time counter.
module tb;
  import ptp_clock_pkg::*;
  logic clk_sys, resetn, regWrite, regRead, txStamped, rxStamped, sum, irq;
  logic [11:0] regAddr;
  logic [31:0] regWriteData, regReadData, rdv, w, snapSec, liveSeconds;
  logic [29:0] snapNs, liveNanoseconds, prevNs;
  logic [7:0]  gpioPins, manualCapture;
  logic [1:0]  targetClearEnable;
  logic [11:0] addrs[6] = '{ADDR_IRQ_ENABLE, ADDR_SECONDS, ADDR_NANOSECONDS, ADDR_SUBNS,
                            ADDR_RATE_ADJUST, 12'h104};
  integer n_errors = 0, checks_done = 0, seed = 32'hA0C5D468, k, d, steps, modelSec, modelNs;
  ptp_clock_counter_irq uut (.clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr),
    .regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
    .regReadData(regReadData), .gpioPins(gpioPins), .manualCapture(manualCapture),
    .targetClearEnable(targetClearEnable), .txStamped(txStamped), .rxStamped(rxStamped),
    .liveSeconds(liveSeconds), .liveNanoseconds(liveNanoseconds),
    .timeEventSummary(sum), .systemIrq(irq));
  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Prints the counts and the verdict, then stops.
  task results;
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  // Compares one value and reports a mismatch.
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // One register write; notes the live time in the cycle it is taken.
  task wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    regAddr <= a;
    regWriteData <= v;
    regWrite <= 1'b1;
    #1;
    snapSec = liveSeconds;
    snapNs = liveNanoseconds;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask : wr
  // One register read; data are taken in the cycle after the strobe.
  task rd(input logic [11:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1;
    rdv = regReadData;
  endtask : rd
  // Holds the input pins at one level for a number of cycles.
  task hold(input logic [7:0] v, input integer n);
    @(posedge clk_sys);
    gpioPins <= v;
    repeat (n - 1) @(posedge clk_sys);
  endtask : hold
  // Advances the model time by one step.
  task tick(input integer s);
    modelNs = modelNs + s;
    if (modelNs >= 1000000000) begin
      modelNs = modelNs - 1000000000;
      modelSec = modelSec + 1;
    end
  endtask : tick
  // Stops a run that hangs.
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    results();
  end
  // Main sequence.
  initial begin
    {resetn, regWrite, regRead, txStamped, rxStamped, targetClearEnable} = '0;
    {regAddr, regWriteData, gpioPins, manualCapture} = '0;
    repeat (6) @(posedge clk_sys);
    resetn <= 1'b1;
    for (k = 0; k < 6; k++) begin
      rd(addrs[k]);
      chk("reset value", 32'h0, rdv);
    end
    rd(ADDR_IRQ_STATUS);
    chk("reset status", 32'h0, rdv & 32'hFFFFFFFC);
    for (k = 0; k < 4; k++) begin
      w = $random(seed);
      wr(ADDR_IRQ_ENABLE, w);
      rd(ADDR_IRQ_ENABLE);
      chk("enable", w & STATUS_MASK, rdv);
    end
    wr(ADDR_IRQ_ENABLE, 32'h0);
    modelSec = $random(seed);
    modelNs = 999999975;
    wr(ADDR_SECONDS, modelSec);
    wr(ADDR_NANOSECONDS, modelNs);
    wr(ADDR_SUBNS, 32'h12345678);
    wr(ADDR_COMMAND, 32'h2);
    for (k = 0; k < 8 && liveNanoseconds !== modelNs[29:0]; k++) @(posedge clk_sys) #1;
    chk("load ns", modelNs, {2'h0, liveNanoseconds});
    for (k = 0; k < 4; k++) begin
      @(posedge clk_sys) #1;
      tick(10);
      chk("seconds", modelSec, liveSeconds);
      chk("nanoseconds", modelNs, {2'h0, liveNanoseconds});
    end
    wr(ADDR_COMMAND, 32'h1);
    rd(ADDR_SECONDS);
    chk("snapshot s", snapSec, rdv);
    rd(ADDR_NANOSECONDS);
    chk("snapshot ns", {2'h0, snapNs}, rdv);
    rd(ADDR_SUBNS);
    chk("snapshot subns", 32'h12345678, rdv);
    for (k = 0; k < 2; k++) begin
      w = {k[0], 1'b1, 30'h20000000};
      wr(ADDR_RATE_ADJUST, w);
      rd(ADDR_RATE_ADJUST);
      chk("rate", w & RATE_MASK, rdv);
      steps = 0;
      prevNs = liveNanoseconds;
      repeat (64) begin
        @(posedge clk_sys) #1;
        d = liveNanoseconds - prevNs;
        if (d < 0) d = d + 1000000000;
        if (d != 10) steps++;
        chk("step", (d == 10) ? 10 : 9 + 2 * k, d);
        prevNs = liveNanoseconds;
      end
      chk("corrections", 8, steps);
    end
    wr(ADDR_RATE_ADJUST, 32'h0);
    wr(ADDR_SYS_IRQ, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h1100);
    @(posedge clk_sys) txStamped <= 1'b1;
    @(posedge clk_sys) txStamped <= 1'b0;
    #1 chk("summary irq", 2'b11, {sum, irq});
    rd(ADDR_SYS_IRQ);
    chk("system irq register", 32'h3, rdv);
    rd(ADDR_IRQ_STATUS);
    chk("tx flag", 32'h1000, rdv & 32'h1100);
    wr(ADDR_IRQ_STATUS, 32'h1000);
    #1 chk("cleared", 1'b0, sum);
    wr(ADDR_SYS_IRQ, 32'h0);
    @(posedge clk_sys) rxStamped <= 1'b1;
    @(posedge clk_sys) rxStamped <= 1'b0;
    #1 chk("gated irq", 2'b10, {sum, irq});
    wr(ADDR_IRQ_ENABLE, 32'h0);
    rd(ADDR_IRQ_STATUS);
    chk("rx flag", 32'h0100, rdv & 32'h1100);
    wr(ADDR_IRQ_STATUS, 32'hFFFF1100);
    hold(8'h01, 7);
    hold(8'h00, 7);
    hold(8'h02, 2);
    hold(8'h00, 7);
    @(posedge clk_sys) manualCapture <= 8'h08;
    @(posedge clk_sys) manualCapture <= 8'h00;
    rd(ADDR_IRQ_STATUS);
    chk("captures", 32'h09090000, rdv & 32'hFFFF0000);
    w = liveSeconds + 32'h5;
    wr(ADDR_TARGET_A_NS, 32'h0);
    wr(ADDR_TARGET_A_S, w);
    wr(ADDR_TARGET_B_NS, 32'h0);
    wr(ADDR_TARGET_B_S, w);
    repeat (4) @(posedge clk_sys);
    wr(ADDR_IRQ_STATUS, 32'h3);
    rd(ADDR_IRQ_STATUS);
    chk("targets clear", 32'h0, rdv & 32'h3);
    w = {2'h0, liveNanoseconds} + 32'd400;
    wr(ADDR_TARGET_A_NS, w);
    wr(ADDR_TARGET_A_S, liveSeconds);
    wr(ADDR_TARGET_B_NS, w);
    wr(ADDR_TARGET_B_S, liveSeconds);
    for (k = 0; k < 100 && rdv[1:0] !== 2'b11; k++) rd(ADDR_IRQ_STATUS);
    chk("targets hit", 32'h3, rdv & 32'h3);
    chk("time reached", 1'b1, {2'h0, liveNanoseconds} >= w);
    wr(ADDR_TARGET_A_S, liveSeconds + 32'h5);
    targetClearEnable <= 2'b01;
    hold(8'h04, 7);
    hold(8'h00, 7);
    rd(ADDR_IRQ_STATUS);
    chk("gpio clear", 32'h2, rdv & 32'h3);
    wr(ADDR_TARGET_B_S, liveSeconds + 32'h5);
    targetClearEnable <= 2'b10;
    hold(8'h04, 7);
    rd(ADDR_IRQ_STATUS);
    chk("gpio clear b", 32'h0, rdv & 32'h3);
    results();
  end
endmodule : tb

/* File: core/gpio_edge_filter.sv */
`timescale 1ns/10ps
// Qualifies one input: an edge counts once the new level held long enough.
module gpio_edge_filter
  import ptp_clock_pkg::*;
(
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic resetn,
  // Input and qualified edges.
  input  wire logic pinLevel,
  output logic      risePulse,
  output logic      fallPulse
);

  logic       stable;
  logic [3:0] runCount;

  // Counts cycles that the input differs from the accepted level.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      stable   <= 1'b0;
      runCount <= 4'h0;
    end else if (pinLevel == stable) begin
      runCount <= 4'h0;
    end else if (runCount == 4'(GPIO_MIN_CYC - 1)) begin
      stable   <= pinLevel;
      runCount <= 4'h0;
    end else begin
      runCount <= runCount + 4'h1;
    end
  end

  // One-cycle pulses when the accepted level changes.
  always_comb begin
    risePulse = (pinLevel != stable) && pinLevel && (runCount == 4'(GPIO_MIN_CYC - 1));
    fallPulse = (pinLevel != stable) && !pinLevel && (runCount == 4'(GPIO_MIN_CYC - 1));
  end

endmodule : gpio_edge_filter

/* File: core/ptp_clock_counter_irq.sv */
`timescale 1ns/10ps
module ptp_clock_counter_irq
  import ptp_clock_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Register port.
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWriteData,
  input  wire logic        regWrite,
  input  wire logic        regRead,
  output logic      [31:0] regReadData,
  // Event inputs.
  input  wire logic [7:0]  gpioPins,
  input  wire logic [7:0]  manualCapture,
  input  wire logic [1:0]  targetClearEnable,
  input  wire logic        txStamped,
  input  wire logic        rxStamped,
  // Time and interrupt outputs.
  output logic      [31:0] liveSeconds,
  output logic      [29:0] liveNanoseconds,
  output logic             timeEventSummary,
  output logic             systemIrq
);

  // ==========================================================================
  // State.
  // The command state only delays a load by one edge; a read snapshot
  // needs no state because it is taken on the edge of the command write.
  typedef enum logic [1:0] {
    CMD_IDLE = 2'b01,
    CMD_LOAD = 2'b10
  } cmd_state_e;

  // Running time, shadows, configuration and event state.
  cmd_state_e  cmdState;
  logic [31:0] seconds;
  logic [29:0] nanoseconds;
  logic [31:0] subns;
  logic [31:0] shadowSeconds;
  logic [29:0] shadowNanoseconds;
  logic [31:0] shadowSubns;
  logic [31:0] rateAdjust;
  logic [31:0] irqEnable;
  logic [31:0] irqStatus;
  logic        summaryEnable;
  logic [31:0] targetSecA;
  logic [29:0] targetNsA;
  logic [31:0] targetSecB;
  logic [29:0] targetNsB;
  logic [1:0]  targetReached;
  logic [7:0]  risePulse;
  logic [7:0]  fallPulse;
  logic [31:0] next_subns;
  logic        subnsWrap;
  logic [31:0] stepNs;
  logic [31:0] next_nsSum;
  logic [31:0] setEvents;
  logic [31:0] clearBits;
  logic        writeStatus;
  logic        cmdRead;
  logic        cmdLoad;

  // Strobes decoded from the register port. The command register is write
  // only; its read bit acts in the cycle of the write, its load bit one cycle later.
  assign writeStatus = regWrite && (regAddr == ADDR_IRQ_STATUS);
  assign cmdRead = regWrite && (regAddr == ADDR_COMMAND) && regWriteData[BIT_CMD_READ];
  assign cmdLoad = regWrite && (regAddr == ADDR_COMMAND) && regWriteData[BIT_CMD_LOAD];

  // ==========================================================================
  // Input qualifiers and target comparators.
  // Every input pin has its own qualifier so that a short glitch on one pin
  // never hides a real edge on another. The comparators are registered, so
  // a target flag appears two edges after the time first reaches it.
  genvar g;
  generate
    for (g = 0; g < GPIO_COUNT; g++) begin : gpioFilters
      gpio_edge_filter filter (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .pinLevel  (gpioPins[g]),
        .risePulse (risePulse[g]),
        .fallPulse (fallPulse[g])
      );
    end
  endgenerate

  time_target_compare compareA (
    .clk_sys           (clk_sys),
    .resetn            (resetn),
    .nowSeconds        (seconds),
    .nowNanoseconds    (nanoseconds),
    .targetSeconds     (targetSecA),
    .targetNanoseconds (targetNsA),
    .reached           (targetReached[0])
  );

  time_target_compare compareB (
    .clk_sys           (clk_sys),
    .resetn            (resetn),
    .nowSeconds        (seconds),
    .nowNanoseconds    (nanoseconds),
    .targetSeconds     (targetSecB),
    .targetNanoseconds (targetNsB),
    .reached           (targetReached[1])
  );

  // ==========================================================================
  // Increment arithmetic.
  // The rate fraction is added to the sub-nanoseconds count every cycle.
  // A carry out of that count replaces the nominal step for one cycle only,
  // with nine or eleven nanoseconds chosen by the direction bit.
  // Only one correction can happen per cycle, so the step never leaves
  // the range of nine to eleven nanoseconds.
  always_comb begin
    {subnsWrap, next_subns} = {1'b0, subns} + {3'b000, rateAdjust[29:0]};
    if (subnsWrap) begin
      stepNs = rateAdjust[BIT_RATE_DIR] ? STEP_FAST : STEP_SLOW;
    end else begin
      stepNs = STEP_NOMINAL;
    end
    next_nsSum = {2'b00, nanoseconds} + stepNs;
  end

  // Load command takes effect one cycle later so the write data is settled.
  // A command that asks for both a snapshot and a load takes the snapshot
  // first; the load then copies the shadows, which by then hold the snapshot.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cmdState <= CMD_IDLE;
    end else begin
      case (cmdState)
        CMD_IDLE: cmdState <= cmdLoad ? CMD_LOAD : CMD_IDLE;
        CMD_LOAD: cmdState <= CMD_IDLE;
        default:  cmdState <= CMD_IDLE;
      endcase
    end
  end

  // Running time counter.
  // A load replaces all three parts at once and skips that cycle's step.
  // The step is far smaller than a second, so the count can pass one second
  // at most once per cycle and a single subtraction keeps it in range.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      seconds     <= RESET_WORD;
      nanoseconds <= RESET_WORD[29:0];
      subns       <= RESET_WORD;
    end else if (cmdState == CMD_LOAD) begin
      seconds     <= shadowSeconds;
      nanoseconds <= shadowNanoseconds;
      subns       <= shadowSubns;
    end else begin
      subns <= next_subns;
      if (next_nsSum >= NS_PER_SECOND) begin
        nanoseconds <= 30'(next_nsSum - NS_PER_SECOND);
        seconds     <= seconds + 32'h00000001;
      end else begin
        nanoseconds <= next_nsSum[29:0];
      end
    end
  end

  // Shadow registers: written by software, or snapshot by read command.
  // The shadows serve both directions: a read command overwrites what
  // software wrote for a load, and a later write overwrites a snapshot.
  // Software that mixes the two must rewrite every part before a load.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      shadowSeconds     <= RESET_WORD;
      shadowNanoseconds <= RESET_WORD[29:0];
      shadowSubns       <= RESET_WORD;
    end else if (cmdRead) begin
      shadowSeconds     <= seconds;
      shadowNanoseconds <= nanoseconds;
      shadowSubns       <= subns;
    end else if (regWrite) begin
      if (regAddr == ADDR_SECONDS) shadowSeconds <= regWriteData;
      if (regAddr == ADDR_NANOSECONDS) shadowNanoseconds <= regWriteData[29:0] & NS_MASK;
      if (regAddr == ADDR_SUBNS) shadowSubns <= regWriteData;
    end
  end

  // Configuration registers.
  // Reserved bits are masked on write so that they always read back as zero.
  // Writes to unmapped offsets fall through and change nothing.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rateAdjust    <= RESET_WORD;
      irqEnable     <= RESET_WORD;
      summaryEnable <= 1'b0;
      targetSecA    <= RESET_WORD;
      targetNsA     <= RESET_WORD[29:0];
      targetSecB    <= RESET_WORD;
      targetNsB     <= RESET_WORD[29:0];
    end else if (regWrite) begin
      case (regAddr)
        ADDR_RATE_ADJUST: rateAdjust <= regWriteData & RATE_MASK;
        ADDR_IRQ_ENABLE:  irqEnable <= regWriteData & STATUS_MASK;
        ADDR_SYS_IRQ:     summaryEnable <= regWriteData[BIT_SYS_EVENT];
        ADDR_TARGET_A_S:  targetSecA <= regWriteData;
        ADDR_TARGET_A_NS: targetNsA <= regWriteData[29:0];
        ADDR_TARGET_B_S:  targetSecB <= regWriteData;
        ADDR_TARGET_B_NS: targetNsB <= regWriteData[29:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Event status: set beats software clear; input edges clear targets.
  // A target flag is set again on every cycle in which the time is still at
  // or past the target, so a software clear only sticks once the target has
  // been moved ahead. A qualified edge on any pin clears the target flags
  // whose clear enable is high, and a set in the same cycle still wins.
  // Capture flags are set by a qualified edge or by a manual capture.
  always_comb begin
    setEvents = RESET_WORD;
    setEvents[BIT_TARGET_A] = targetReached[0];
    setEvents[BIT_TARGET_B] = targetReached[1];
    setEvents[BIT_RX_STAMP] = rxStamped;
    setEvents[BIT_TX_STAMP] = txStamped;
    setEvents[LSB_GPIO_RISE +: GPIO_COUNT] = risePulse | manualCapture;
    setEvents[LSB_GPIO_FALL +: GPIO_COUNT] = fallPulse | manualCapture;
    clearBits = writeStatus ? regWriteData : RESET_WORD;
    clearBits[BIT_TARGET_A] = clearBits[BIT_TARGET_A] ||
                              (targetClearEnable[0] && |(risePulse | fallPulse));
    clearBits[BIT_TARGET_B] = clearBits[BIT_TARGET_B] ||
                              (targetClearEnable[1] && |(risePulse | fallPulse));
  end

  // Status register: clears and sets land together on each edge, and
  // reserved bits are masked so that they can never be set.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irqStatus <= RESET_WORD;
    end else begin
      irqStatus <= ((irqStatus & ~clearBits) | setEvents) & STATUS_MASK;
    end
  end

  // Summary and system interrupt.
  // Both outputs are plain gates on registers, so they change on the same
  // edge as a flag or an enable, with no added cycle.
  assign timeEventSummary = |(irqStatus & irqEnable);
  assign systemIrq = timeEventSummary && summaryEnable;

  // ==========================================================================
  // Read data, valid the cycle after the read strobe.
  // Outside that cycle the data are driven to zero, so a stale value is
  // never mistaken for a fresh one.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      regReadData <= RESET_WORD;
    end else if (regRead) begin
      case (regAddr)
        ADDR_IRQ_STATUS:  regReadData <= irqStatus;
        ADDR_IRQ_ENABLE:  regReadData <= irqEnable;
        ADDR_SECONDS:     regReadData <= shadowSeconds;
        ADDR_NANOSECONDS: regReadData <= {2'b00, shadowNanoseconds};
        ADDR_SUBNS:       regReadData <= shadowSubns;
        ADDR_RATE_ADJUST: regReadData <= rateAdjust;
        ADDR_TARGET_A_S:  regReadData <= targetSecA;
        ADDR_TARGET_A_NS: regReadData <= {2'b00, targetNsA};
        ADDR_TARGET_B_S:  regReadData <= targetSecB;
        ADDR_TARGET_B_NS: regReadData <= {2'b00, targetNsB};
        ADDR_SYS_IRQ:     regReadData <= {30'h0, timeEventSummary, summaryEnable};
        default:          regReadData <= RESET_WORD;
      endcase
    end else begin
      regReadData <= RESET_WORD;
    end
  end

  // The running time is also offered live, for timestamping logic nearby
  // that cannot wait for a snapshot.
  assign liveSeconds = seconds;
  assign liveNanoseconds = nanoseconds;

endmodule : ptp_clock_counter_irq

/* File: core/time_target_compare.sv */
`timescale 1ns/10ps
// Registered test that the running time has reached a target.
module time_target_compare
  import ptp_clock_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  // Running time and target.
  input  wire logic [31:0] nowSeconds,
  input  wire logic [29:0] nowNanoseconds,
  input  wire logic [31:0] targetSeconds,
  input  wire logic [29:0] targetNanoseconds,
  // Reached indication.
  output logic             reached
);

  // Equal or later: seconds greater, or seconds equal and nanoseconds not less.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reached <= 1'b0;
    end else begin
      reached <= (nowSeconds > targetSeconds) ||
                 ((nowSeconds == targetSeconds) && (nowNanoseconds >= targetNanoseconds));
    end
  end

endmodule : time_target_compare

/* File: include/ptp_clock_pkg.sv */
package ptp_clock_pkg;

  // ==========================================================================
  // Register offsets (byte addresses).
  localparam logic [11:0] ADDR_IRQ_STATUS  = 12'h108;
  localparam logic [11:0] ADDR_IRQ_ENABLE  = 12'h10C;
  localparam logic [11:0] ADDR_SECONDS     = 12'h110;
  localparam logic [11:0] ADDR_NANOSECONDS = 12'h114;
  localparam logic [11:0] ADDR_SUBNS       = 12'h118;
  localparam logic [11:0] ADDR_RATE_ADJUST = 12'h11C;
  localparam logic [11:0] ADDR_COMMAND     = 12'h100;
  localparam logic [11:0] ADDR_TARGET_A_S  = 12'h12C;
  localparam logic [11:0] ADDR_TARGET_A_NS = 12'h130;
  localparam logic [11:0] ADDR_TARGET_B_S  = 12'h13C;
  localparam logic [11:0] ADDR_TARGET_B_NS = 12'h140;
  localparam logic [11:0] ADDR_SYS_IRQ     = 12'h150;

  // ==========================================================================
  // Field positions.
  localparam int BIT_TARGET_A   = 0;
  localparam int BIT_TARGET_B   = 1;
  localparam int BIT_RX_STAMP   = 8;
  localparam int BIT_TX_STAMP   = 12;
  localparam int LSB_GPIO_RISE  = 16;
  localparam int LSB_GPIO_FALL  = 24;
  localparam int BIT_RATE_DIR   = 31;
  localparam int BIT_CMD_READ   = 0;
  localparam int BIT_CMD_LOAD   = 1;
  localparam int BIT_SYS_EVENT  = 0;
  localparam int GPIO_COUNT     = 8;
  localparam logic [31:0] STATUS_MASK  = 32'hFFFF1103;
  localparam logic [31:0] RATE_MASK    = 32'hBFFFFFFF;
  localparam logic [29:0] NS_MASK      = 30'h3FFFFFFF;

  // ==========================================================================
  // Reset values and timing.
  localparam logic [31:0] RESET_WORD    = 32'h00000000;
  localparam logic [31:0] NS_PER_SECOND = 32'h3B9ACA00;
  localparam int          CLK_PERIOD_NS = 10;
  localparam logic [31:0] STEP_NOMINAL  = 32'h0000000A;
  localparam logic [31:0] STEP_SLOW     = 32'h00000009;
  localparam logic [31:0] STEP_FAST     = 32'h0000000B;
  localparam int          GPIO_MIN_NS   = 40;
  // Least hold time, rounded up to whole cycles, plus one.
  localparam int          GPIO_MIN_CYC  = (GPIO_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;

endpackage : ptp_clock_pkg
